// file: src/kplock_hold_timer.v
// Hold timer: reports when a key has been held continuously for hold_cyc_i cycles.
// Assumes the key level is synchronous and debounced.
`timescale 1ns/1ps
module kplock_hold_timer (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  // Key level and length
  input  wire        key_i,
  input  wire [39:0] hold_cyc_i,
  // One-cycle pulse when the hold completes
  output reg         held_o
);
  reg [39:0] cnt_r;

  // The count saturates so a key held on after the pulse gives no second pulse.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r  <= 40'h0;
      held_o <= 1'b0;
    end else begin
      held_o <= 1'b0;
      if (!key_i) begin
        cnt_r <= 40'h0;
      end else if (cnt_r < hold_cyc_i) begin
        cnt_r <= cnt_r + 40'h1;
        if (cnt_r == hold_cyc_i - 40'h1) begin
          held_o <= 1'b1;
        end
      end
    end
  end
endmodule // kplock_hold_timer

// file: src/kplock_map.vh
// Constants for the keypad lock and default restore supervisor.
// Assumes a 200 MHz system clock; included by the top design file only.
`ifndef KPLOCK_MAP_VH
`define KPLOCK_MAP_VH
`define KPLOCK_CLK_MHZ      200
`define KPLOCK_HOLD_MS      5000
// Hold length in clock cycles, sized to the hold timer's 40-bit count.
`define KPLOCK_HOLD_CYC     40'd1000000000
`define KPLOCK_CODE_DEFAULT 12'h123
`define KPLOCK_DIGIT_W      4
`define KPLOCK_CODE_W       12
`endif

// file: src/kplock_top.v
// Keypad lock and default-restore supervisor of the front panel.
// Assumes key inputs are debounced levels and digit strobes last one cycle.
`timescale 1ns/1ps
`include "kplock_map.vh"

// What this block does
// - Hold Enter full interval, then prompt code
// - Correct code at lock prompt locks keypad
// - Hold Enter again, correct code unlocks
// - Three decimal digit code, factory value 123
// - Code changed from computer interface, or to 123 by default restore
// - Restoring defaults also restores factory code
// - Locked keypad refuses front-panel default restore
// - Locked edits rejected with locked message
// - Heater off and alarm reset still allowed
// - Hold Escape opens default-restore first screen
// - Screen one toggles, Enter advances, Escape abandons
// - Screen two curve clear, both keys exit
// - Parameter and curve areas cleared independently
module kplock_top #(
  parameter [39:0] HOLD_CYC = `KPLOCK_HOLD_CYC
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  // Front-panel keys
  input  wire        key_enter_i,
  input  wire        key_escape_i,
  input  wire        key_updown_stb_i,
  input  wire        digit_stb_i,
  input  wire [3:0]  digit_i,
  // Front-panel edit requests
  input  wire        edit_req_i,
  input  wire        heater_off_req_i,
  input  wire        alarm_reset_req_i,
  input  wire        heater_range_req_i,
  // Computer interface
  input  wire        host_code_wr_i,
  input  wire [11:0] host_code_i,
  // Screen and state
  output reg  [4:0]  screen_o,
  output reg         locked_o,
  output reg         locked_msg_o,
  output reg         select_yes_o,
  output reg  [11:0] code_o,
  // Actions granted
  output reg         edit_ok_o,
  output reg         heater_off_o,
  output reg         alarm_reset_o,
  output reg         heater_range_ok_o,
  // Nonvolatile store clears
  output reg         param_clear_o,
  output reg         curve_clear_o
);
  localparam [4:0] ST_NORMAL = 5'h01;
  localparam [4:0] ST_LOCK_P = 5'h02;
  localparam [4:0] ST_UNLK_P = 5'h04;
  localparam [4:0] ST_DEF_1  = 5'h08;
  localparam [4:0] ST_DEF_2  = 5'h10;

  reg  [4:0]  state_r;
  reg  [4:0]  state_nxt;
  reg  [11:0] entry_r;
  reg  [1:0]  ndig_r;
  reg         enter_d_r;
  reg         escape_d_r;
  wire        enter_hold;
  wire        escape_hold;
  wire        enter_rel;
  wire        escape_rel;
  wire        code_done;
  reg         enter_arm_r;
  reg         escape_arm_r;
  wire        enter_act;
  wire        escape_act;
  wire        host_code_bcd;

  // One timer per key; each gives a single pulse per continuous hold.
  kplock_hold_timer u_enter_hold (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .key_i     (key_enter_i),
    .hold_cyc_i(HOLD_CYC),
    .held_o    (enter_hold)
  );

  kplock_hold_timer u_escape_hold (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .key_i     (key_escape_i),
    .hold_cyc_i(HOLD_CYC),
    .held_o    (escape_hold)
  );

  // Keys act in menus on release, and only once they have been seen up on the
  // current screen, so releasing the long hold that opened a screen never also
  // answers it.
  assign enter_rel  = enter_d_r & ~key_enter_i;
  assign escape_rel = escape_d_r & ~key_escape_i;
  assign enter_act  = enter_rel & enter_arm_r;
  assign escape_act = escape_rel & escape_arm_r;
  // Only a decimal third digit completes the code; others are ignored.
  assign code_done  = digit_stb_i & (digit_i <= 4'h9) & (ndig_r == 2'h2);
  // A host code with a non-decimal digit is dropped, so the stored code can
  // always be matched from the keypad.
  assign host_code_bcd = (host_code_i[11:8] <= 4'h9) & (host_code_i[7:4] <= 4'h9)
                         & (host_code_i[3:0] <= 4'h9);

  // Screen sequencer. Requests made while a menu or prompt is open are ignored,
  // because the operator cannot see their result there.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL: begin
        if (enter_hold) begin
          state_nxt = locked_o ? ST_UNLK_P : ST_LOCK_P;
        end else if (escape_hold) begin
          state_nxt = ST_DEF_1;
        end
      end
      ST_LOCK_P, ST_UNLK_P: begin
        if (code_done || escape_act) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_DEF_1: begin
        if (escape_act) begin
          state_nxt = ST_NORMAL;
        end else if (enter_act) begin
          state_nxt = ST_DEF_2;
        end
      end
      ST_DEF_2: begin
        if (escape_act || enter_act) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: begin
        state_nxt = ST_NORMAL;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r           <= ST_NORMAL;
      entry_r           <= 12'h000;
      ndig_r            <= 2'h0;
      enter_d_r         <= 1'b0;
      escape_d_r        <= 1'b0;
      enter_arm_r       <= 1'b0;
      escape_arm_r      <= 1'b0;
      screen_o          <= ST_NORMAL;
      locked_o          <= 1'b0;
      locked_msg_o      <= 1'b0;
      select_yes_o      <= 1'b0;
      code_o            <= `KPLOCK_CODE_DEFAULT;
      edit_ok_o         <= 1'b0;
      heater_off_o      <= 1'b0;
      alarm_reset_o     <= 1'b0;
      heater_range_ok_o <= 1'b0;
      param_clear_o     <= 1'b0;
      curve_clear_o     <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      screen_o          <= state_nxt;
      enter_d_r         <= key_enter_i;
      escape_d_r        <= key_escape_i;
      // Any screen change disarms both keys until each is seen up again.
      enter_arm_r       <= (state_r == state_nxt) & (enter_arm_r | ~key_enter_i);
      escape_arm_r      <= (state_r == state_nxt) & (escape_arm_r | ~key_escape_i);
      param_clear_o     <= 1'b0;
      curve_clear_o     <= 1'b0;
      // Grants are pulses; only requests made on the normal display count.
      edit_ok_o         <= (state_r == ST_NORMAL) & edit_req_i & ~locked_o;
      locked_msg_o      <= (state_r == ST_NORMAL) & locked_o
                           & (edit_req_i | heater_range_req_i);
      heater_off_o      <= (state_r == ST_NORMAL) & heater_off_req_i;
      alarm_reset_o     <= (state_r == ST_NORMAL) & alarm_reset_req_i;
      heater_range_ok_o <= (state_r == ST_NORMAL) & heater_range_req_i
                           & ~locked_o;
      // Digits are taken only as decimal; non-decimal strobes are ignored.
      if (state_r != state_nxt) begin
        entry_r <= 12'h000;
        ndig_r  <= 2'h0;
      end else if (digit_stb_i && (digit_i <= 4'h9) && !code_done) begin
        entry_r <= {entry_r[7:0], digit_i};
        ndig_r  <= ndig_r + 2'h1;
      end
      // The third digit is compared together with the two held ones, so a
      // match takes effect on the edge that returns to the normal display.
      if (state_r == ST_LOCK_P && code_done && digit_i <= 4'h9
          && {entry_r[7:0], digit_i} == code_o) begin
        locked_o <= 1'b1;
      end
      if (state_r == ST_UNLK_P && code_done && digit_i <= 4'h9
          && {entry_r[7:0], digit_i} == code_o) begin
        locked_o <= 1'b0;
      end
      if (state_nxt == ST_DEF_1 && state_r != ST_DEF_1) begin
        select_yes_o <= 1'b0;
      end else if ((state_r == ST_DEF_1 || state_r == ST_DEF_2) && key_updown_stb_i) begin
        select_yes_o <= ~select_yes_o;
      end
      // A locked keypad still walks both screens but never clears parameters;
      // the curve screen stays usable.
      if (state_r == ST_DEF_1 && enter_act) begin
        select_yes_o <= 1'b0;
        if (select_yes_o && !locked_o) begin
          param_clear_o <= 1'b1;
          locked_o      <= 1'b0;
          code_o        <= `KPLOCK_CODE_DEFAULT;
        end
      end else if (host_code_wr_i && host_code_bcd) begin
        code_o <= host_code_i;
      end
      if (state_r == ST_DEF_2 && enter_act && select_yes_o) begin
        curve_clear_o <= 1'b1;
      end
    end
  end
endmodule // kplock_top

// file: verification/kplock_checker.sv
// Checker for the keypad lock and default restore supervisor.
// Assumes it is bound to kplock_top and sees only that module's ports.
`timescale 1ns/1ps
module kplock_checker #(parameter [39:0] HOLD_CYC = 40'd10) (
  // Clock and reset
  input wire        sys_clk_i,
  input wire        reset_n_i,
  // Requests
  input wire        edit_req_i,
  input wire        heater_off_req_i,
  input wire        heater_range_req_i,
  input wire        host_code_wr_i,
  // Outputs watched
  input wire [4:0]  screen_o,
  input wire        locked_o,
  input wire        locked_msg_o,
  input wire [11:0] code_o,
  input wire        edit_ok_o,
  input wire        heater_off_o,
  input wire        heater_range_ok_o,
  input wire        param_clear_o,
  input wire        curve_clear_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_normal; screen_o == 5'h01; endsequence
  sequence s_locked_edit; s_normal ##0 edit_req_i && locked_o; endsequence
  AST_LOCK_MSG: assert property (
    s_locked_edit |=> locked_msg_o && !edit_ok_o) else $error("locked edit not refused");
  AST_EDIT_OK: assert property (
    s_normal ##0 edit_req_i && !locked_o |=> edit_ok_o) else $error("edit not granted");
  AST_HEAT_OFF: assert property (
    s_normal ##0 heater_off_req_i |=> heater_off_o) else $error("heater off not granted");
  AST_RANGE: assert property (
    s_normal ##0 heater_range_req_i && locked_o |=> !heater_range_ok_o) else $error("range granted");
  AST_LOCK_ROSE: assert property (
    $rose(locked_o) |-> s_normal ##0 $past(screen_o) == 5'h02) else $error("lock not from prompt");
  AST_PCLR: assert property (
    param_clear_o |-> code_o == 12'h123 && !locked_o && screen_o == 5'h10) else $error("bad restore");
  AST_PCLR_LOCK: assert property (
    param_clear_o |-> !$past(locked_o)) else $error("restore while locked");
  AST_CCLR: assert property (
    curve_clear_o |-> s_normal ##0 $past(screen_o) == 5'h10) else $error("bad curve clear");
  AST_CODE: assert property (
    $changed(code_o) |-> $past(host_code_wr_i) || param_clear_o) else $error("code changed");
endmodule // kplock_checker
bind kplock_top kplock_checker #(.HOLD_CYC(HOLD_CYC)) chk (.*);

// file: verification/kplock_panel_model.sv
// Front-panel operator: key levels, up/down and digit strobes.
// Assumes its caller starts each task just after a falling clock edge.
`timescale 1ns/1ps
module kplock_panel_model #(parameter int HOLD = 10) (
  input  wire        clk_i,
  output logic [1:0] key_o,
  output logic       updown_o,
  output logic       dstb_o,
  output logic [3:0] digit_o
);
  initial {key_o, updown_o, dstb_o, digit_o} = 8'h00;
  // A held key stays pressed a few cycles past the count so a one-off slip still completes the hold.
  task automatic hold_key(input int k, input int n = HOLD + 3);
    key_o[k] = 1'b1;
    repeat (n) @(negedge clk_i);
    key_o[k] = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic digit(input logic [3:0] d);
    {dstb_o, digit_o} = {1'b1, d};
    @(negedge clk_i);
    {dstb_o, digit_o} = {1'b0, ~d};
    @(negedge clk_i);
  endtask
  task automatic toggle();
    updown_o = 1'b1;
    @(negedge clk_i);
    updown_o = 1'b0;
    @(negedge clk_i);
  endtask
endmodule // kplock_panel_model

// file: verification/kplock_tb.sv
// Testbench for kplock_top with a short hold count.
// Assumes the panel model drives keys and the bench drives other requests.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk_i = 0, reset_n_i = 0, host_code_wr_i = 0;
  logic [3:0]  req = 4'h0;
  logic [11:0] host_code_i = 12'h000;
  logic [1:0]  key;
  logic        upd, dstb, clr = 0;
  logic [3:0]  dig;
  wire  [4:0]  screen;
  wire  [11:0] code;
  wire  [6:0]  pul;
  wire         locked, sel;
  logic [6:0]  seen = 7'h00;
  int          err_count = 0, n_compared = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) seen <= clr ? 7'h00 : seen | pul;
  kplock_panel_model pm (.clk_i(sys_clk_i), .key_o(key), .updown_o(upd), .dstb_o(dstb),
    .digit_o(dig));
  kplock_top #(.HOLD_CYC(40'd10)) dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .key_enter_i(key[0]), .key_escape_i(key[1]), .key_updown_stb_i(upd), .digit_stb_i(dstb),
    .digit_i(dig), .edit_req_i(req[3]), .heater_off_req_i(req[2]), .alarm_reset_req_i(req[1]),
    .heater_range_req_i(req[0]), .host_code_wr_i(host_code_wr_i), .host_code_i(host_code_i),
    .screen_o(screen), .locked_o(locked), .locked_msg_o(pul[6]), .select_yes_o(sel),
    .code_o(code), .edit_ok_o(pul[3]), .heater_off_o(pul[2]), .alarm_reset_o(pul[1]),
    .heater_range_ok_o(pul[0]), .param_clear_o(pul[5]), .curve_clear_o(pul[4]));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pulses are gathered since the last call, so their exact cycle does not matter here.
  task automatic pulses(input logic [6:0] exp);
    repeat (2) @(negedge sys_clk_i);
    chk({5'h00, seen}, {5'h00, exp});
    clr = 1;
    @(negedge sys_clk_i);
    clr = 0;
  endtask
  task automatic code_in(input logic [11:0] c, input logic [11:0] prompt);
    pm.hold_key(0);
    chk({7'h00, screen}, prompt);
    for (int i = 2; i >= 0; i--) pm.digit(c[i*4 +: 4]);
    pulses(7'h00);
  endtask
  task automatic tap(input logic [3:0] r);
    req = r;
    @(negedge sys_clk_i);
    req = 4'h0;
    @(negedge sys_clk_i);
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (5) @(negedge sys_clk_i);
    reset_n_i = 1;
    chk(code, 12'h123);
    tap(4'h8); pulses(7'h08);
    code_in(12'h124, 12'h002); chk({11'h0, locked}, 12'h000);
    code_in(12'h123, 12'h002); chk({11'h0, locked}, 12'h001);
    tap(4'h8); pulses(7'h40);
    tap(4'h6); tap(4'h1); pulses(7'h46);
    pm.hold_key(1); chk({7'h00, screen}, 12'h008);
    pm.toggle(); pm.hold_key(0, 2); chk({7'h00, screen}, 12'h010);
    pm.hold_key(1, 2); pulses(7'h00); chk({7'h00, screen}, 12'h001);
    host_code_wr_i = 1; host_code_i = 12'h456; @(negedge sys_clk_i); host_code_wr_i = 0;
    pulses(7'h00); chk(code, 12'h456);
    code_in(12'h456, 12'h004); chk({11'h0, locked}, 12'h000);
    pm.hold_key(1); pm.hold_key(1, 2); chk({7'h00, screen}, 12'h001);
    pm.hold_key(1); pm.toggle(); chk({11'h0, sel}, 12'h001);
    pm.hold_key(0, 2); pulses(7'h20); chk(code, 12'h123);
    pm.toggle(); pm.hold_key(0, 2); pulses(7'h10); chk({7'h00, screen}, 12'h001);
    final_report();
  end
endmodule // testbench
